/* rtl/dsrm_self_refresh.sv */
package dsrm_pkg;
  localparam int       LP_W          = 3;      // low-power select width
  localparam int       TIM_W         = 4;      // idle timer field width
  localparam int       IDLE_W        = 19;     // idle count width
  localparam int       MIN_SHIFT     = 3;      // threshold = 1 << (timer+3)
  localparam logic [LP_W-1:0]  LP_SELF_REFRESH = 3'h2;
  localparam logic [TIM_W-1:0] TIM_SAFE  = 4'h9;
  localparam logic [IDLE_W-1:0] SAFE_IDLE = 19'h01000; // 4096 cycles
  localparam int       CLK_PERIOD_NS = 100;
  localparam int       WINDOW_NS     = 15600;  // two refresh intervals
  localparam int       WINDOW_CYC    = WINDOW_NS / CLK_PERIOD_NS;
  localparam int       REF_MAX       = 16;     // refreshes per window
  localparam int       AGE_W         = 8;
  localparam int       PTR_W         = 4;
  typedef enum logic [2:0] {
    DSRM_AWAKE, DSRM_ENTER, DSRM_ASLEEP, DSRM_EXIT
  } dsrm_state_t;
endpackage : dsrm_pkg

// How it works
// - With low-power select at 0x2 the memory is put into self-refresh.
// - A command that arrives during self-refresh first wakes the memory.
// - After work ends the block idles for the timer-set count, then sleeps.
// - One refresh goes out on each entry and one on each exit.
// - A timer field of 0x9 or more gives at least 4096 idle cycles.
module dsrm_self_refresh (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [dsrm_pkg::LP_W-1:0]  low_power_select,
  input  wire logic [dsrm_pkg::TIM_W-1:0] self_refresh_idle_timer,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic                       cmd_pending,
  output logic                            mem_refresh,
  output logic                            mem_sr_enter,
  output logic                            mem_sr_exit,
  output logic                            in_self_refresh
);
  import dsrm_pkg::*;

  // idle threshold grows by powers of two with the timer field
  function automatic logic [IDLE_W-1:0] idle_limit(
    input logic [TIM_W-1:0] tim
  );
    idle_limit = IDLE_W'(1) << (IDLE_W'(tim) + IDLE_W'(MIN_SHIFT));
  endfunction : idle_limit

  dsrm_state_t            state;
  dsrm_state_t            next_state;
  logic [IDLE_W-1:0]      idle_cnt;
  logic [IDLE_W-1:0]      next_idle_cnt;
  logic [AGE_W-1:0]       age [REF_MAX];
  logic [PTR_W-1:0]       ref_ptr;
  logic                   next_refresh;
  logic                   next_enter;
  logic                   next_exit;

  // decode of mode, threshold and refresh budget
  wire sr_selected = (low_power_select == LP_SELF_REFRESH);
  wire [IDLE_W-1:0] limit = idle_limit(self_refresh_idle_timer);
  wire idle_done   = (idle_cnt >= limit) && !cmd_pending;
  wire ref_ok      = (age[ref_ptr] == '0);
  wire cmd_take    = cmd_valid && cmd_ready;
  assign cmd_ready = (state == DSRM_AWAKE);

  // next state and pulses
  always_comb begin
    next_state    = state;
    next_refresh  = 1'b0;
    next_enter    = 1'b0;
    next_exit     = 1'b0;
    next_idle_cnt = idle_cnt;
    unique case (state)
      DSRM_AWAKE: begin
        if (cmd_take || cmd_pending) begin
          next_idle_cnt = '0;
        end else if (idle_cnt != {IDLE_W{1'b1}}) begin
          next_idle_cnt = idle_cnt + IDLE_W'(1);
        end
        if (sr_selected && idle_done && !cmd_valid) begin
          next_state = DSRM_ENTER;
        end
      end
      DSRM_ENTER: begin
        if (cmd_valid || !sr_selected) begin
          next_state = DSRM_AWAKE;
        end else if (ref_ok) begin
          next_refresh = 1'b1;
          next_enter   = 1'b1;
          next_state   = DSRM_ASLEEP;
        end
      end
      DSRM_ASLEEP: begin
        if (cmd_valid || !sr_selected) begin
          next_state = DSRM_EXIT;
        end
      end
      DSRM_EXIT: begin
        if (ref_ok) begin
          next_refresh  = 1'b1;
          next_exit     = 1'b1;
          next_idle_cnt = '0;
          next_state    = DSRM_AWAKE;
        end
      end
      default: next_state = DSRM_AWAKE;
    endcase
  end

  // state and output registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state           <= DSRM_AWAKE;
      idle_cnt        <= '0;
      mem_refresh     <= 1'b0;
      mem_sr_enter    <= 1'b0;
      mem_sr_exit     <= 1'b0;
      in_self_refresh <= 1'b0;
    end else begin
      state           <= next_state;
      idle_cnt        <= next_idle_cnt;
      mem_refresh     <= next_refresh;
      mem_sr_enter    <= next_enter;
      mem_sr_exit     <= next_exit;
      in_self_refresh <= (next_state == DSRM_ASLEEP) ||
                         (next_state == DSRM_EXIT);
    end
  end

  // ring of refresh ages: a slot frees once its refresh leaves the window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_ptr <= '0;
      for (int i = 0; i < REF_MAX; i++) begin
        age[i] <= '0;
      end
    end else begin
      for (int i = 0; i < REF_MAX; i++) begin
        if (next_refresh && PTR_W'(i) == ref_ptr) begin
          age[i] <= AGE_W'(WINDOW_CYC);
        end else if (age[i] != '0) begin
          age[i] <= age[i] - AGE_W'(1);
        end
      end
      if (next_refresh) begin
        ref_ptr <= ref_ptr + PTR_W'(1);
      end
    end
  end

  // checks
  a_entry_needs_select: assert property (@(posedge clk) disable iff (!rst_n)
    mem_sr_enter |-> $past(sr_selected))
    else $error("self-refresh entered without select 0x2");
  a_cmd_while_awake: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take |-> !in_self_refresh && !mem_sr_enter)
    else $error("command taken while memory asleep");
  a_idle_before_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_AWAKE && next_state == DSRM_ENTER)
      |-> idle_cnt >= limit && !cmd_pending)
    else $error("entry before idle count reached");
  a_refresh_pairs: assert property (@(posedge clk) disable iff (!rst_n)
    mem_refresh == (mem_sr_enter || mem_sr_exit))
    else $error("refresh not paired with entry or exit");
  a_safe_idle_min: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_AWAKE && next_state == DSRM_ENTER &&
     self_refresh_idle_timer >= TIM_SAFE) |-> idle_cnt >= SAFE_IDLE)
    else $error("timer 0x9 or more gave under 4096 idle cycles");
  a_refresh_budget: assert property (@(posedge clk) disable iff (!rst_n)
    mem_refresh |-> $past(ref_ok))
    else $error("refresh issued with window budget spent");
  a_idle_restart: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take |=> idle_cnt == '0 ##1 state != DSRM_ENTER)
    else $error("idle count not restarted by command");
  // a command seen during self-refresh starts the exit
  a_wake_on_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_ASLEEP && cmd_valid) |=> state == DSRM_EXIT)
    else $error("command did not wake the memory");
  // a command during entry aborts it without a refresh
  a_enter_abort: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_ENTER && cmd_valid) |=> state == DSRM_AWAKE && !mem_refresh)
    else $error("entry not aborted by command");
  // dropping the select wakes the memory
  a_select_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_ASLEEP && !sr_selected) |=> state == DSRM_EXIT)
    else $error("memory kept asleep without select");
  // pending work holds the idle count at zero
  a_pending_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_AWAKE && cmd_pending)
      |=> idle_cnt == '0 && state == DSRM_AWAKE)
    else $error("idle count ran while work pending");
  // quiet awake cycles count up one by one
  a_idle_counts: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_AWAKE && !cmd_take && !cmd_pending && idle_cnt < limit)
      |=> idle_cnt == $past(idle_cnt) + IDLE_W'(1))
    else $error("idle count did not advance");
  // the exit restarts the idle count
  a_exit_clears_idle: assert property (@(posedge clk) disable iff (!rst_n)
    mem_sr_exit |-> idle_cnt == '0)
    else $error("idle count not cleared on exit");
  // entry only from awake, exit only from asleep
  a_enter_from_awake: assert property (@(posedge clk) disable iff (!rst_n)
    mem_sr_enter |-> !$past(in_self_refresh))
    else $error("entry while already asleep");
  a_exit_from_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    mem_sr_exit |-> $past(in_self_refresh))
    else $error("exit while not asleep");
  // refresh pulses never run back to back
  a_pulse_single: assert property (@(posedge clk) disable iff (!rst_n)
    mem_refresh |=> !mem_refresh)
    else $error("refresh pulse longer than one cycle");
  // no refresh while the memory just sleeps
  a_quiet_asleep: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_ASLEEP && $past(state) == DSRM_ASLEEP) |-> !mem_refresh)
    else $error("refresh issued during self-refresh");
  // a spent budget holds the exit back
  a_exit_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (state == DSRM_EXIT && !ref_ok) |=> state == DSRM_EXIT)
    else $error("exit refresh issued with budget spent");
endmodule : dsrm_self_refresh

/* tb/dsrm_mem_model.sv */
module dsrm_mem_model import dsrm_pkg::*; (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic mem_refresh,
  input  wire logic mem_sr_enter,
  input  wire logic mem_sr_exit,
  output logic      fault
);
  timeunit 1ns;
  timeprecision 1ns;
  int   hist[$]; // cycle stamps of recent refreshes
  int   cyc = 0;
  logic asleep;
  // memory state, pairing of refresh with entry and exit, refresh budget
  always @(posedge clk) begin
    cyc++;
    if (!rst_n) begin
      asleep <= 1'b0;
      fault  <= 1'b0;
    end else begin
      if ((mem_sr_enter | mem_sr_exit) != mem_refresh) fault <= 1'b1;
      if ((mem_sr_enter & asleep) | (mem_sr_exit & !asleep)) fault <= 1'b1;
      if (mem_sr_enter) asleep <= 1'b1;
      if (mem_sr_exit) asleep <= 1'b0;
      if (mem_refresh) hist.push_back(cyc);
      while (hist.size() > 0 && cyc - hist[0] >= WINDOW_CYC) hist.pop_front();
      if (hist.size() > REF_MAX) fault <= 1'b1;
    end
  end
endmodule : dsrm_mem_model

/* tb/tb_ddr3_self_refresh_manager.sv */
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module tb_ddr3_self_refresh_manager import dsrm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, cmd_valid, cmd_ready, cmd_pending, fault;
  logic mem_refresh, mem_sr_enter, mem_sr_exit, in_self_refresh;
  logic [LP_W-1:0]  low_power_select;
  logic [TIM_W-1:0] self_refresh_idle_timer;
  int errors = 0, n_tests = 0, n, n_exit = 0;
  logic [TIM_W-1:0] row_tim [4] = '{4'h0, 4'h1, 4'h3, 4'h9};
  int               row_min [4] = '{8, 16, 64, 4096};
  dsrm_self_refresh u_dut (.clk(clk), .rst_n(rst_n),
    .low_power_select(low_power_select),
    .self_refresh_idle_timer(self_refresh_idle_timer),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_pending(cmd_pending),
    .mem_refresh(mem_refresh), .mem_sr_enter(mem_sr_enter),
    .mem_sr_exit(mem_sr_exit), .in_self_refresh(in_self_refresh));
  dsrm_mem_model u_mem (.clk(clk), .rst_n(rst_n), .mem_refresh(mem_refresh),
    .mem_sr_enter(mem_sr_enter), .mem_sr_exit(mem_sr_exit), .fault(fault));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count exit pulses
  always @(posedge clk) n_exit += (mem_sr_exit === 1'b1);
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // hold a command until it is taken
  task automatic send_cmd();
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #5 cmd_valid = 1'b0;
  endtask : send_cmd
  // cycles from now until the entry pulse
  task automatic to_sleep(output int c);
    c = 1;
    while (mem_sr_enter !== 1'b1 && c < 5000) begin
      @(posedge clk);
      #5 c++;
    end
  endtask : to_sleep
  // watchdog
  initial begin
    #2ms errors++;
    conclude();
  end
  initial begin
    {rst_n, cmd_valid, cmd_pending} = 3'h0;
    low_power_select = 3'h0;
    self_refresh_idle_timer = 4'h0;
    repeat (20) @(posedge clk);
    #5 `CHK("ready at reset", 1'b1, cmd_ready)
    `CHK("sleep at reset", 1'b0, in_self_refresh)
    rst_n = 1'b1;
    low_power_select = LP_SELF_REFRESH;
    for (int i = 0; i < 4; i++) begin
      self_refresh_idle_timer = row_tim[i];
      send_cmd();
      to_sleep(n);
      `CHK("idle span ok", 1'b1, n >= row_min[i] && n <= row_min[i] + 4)
      `CHK("asleep", 1'b1, in_self_refresh)
    end
    `CHK("exit pulses", 3, n_exit)
    self_refresh_idle_timer = 4'h0;
    send_cmd();
    repeat (5) @(posedge clk);
    #5 send_cmd();
    to_sleep(n);
    `CHK("idle restart", 1'b1, n >= 8)
    cmd_pending = 1'b1;
    send_cmd();
    repeat (20) @(posedge clk);
    #5 `CHK("pending holds", 1'b0, in_self_refresh)
    cmd_pending = 1'b0;
    repeat (12) begin
      to_sleep(n);
      send_cmd();
    end
    `CHK("memory model", 1'b0, fault)
    conclude();
  end
endmodule : tb_ddr3_self_refresh_manager
